// file: dv/rcd_ext_load.sv
// external part that samples the reference pin on the system clock
// assumes the pin level is resolved by the bench and clk is the system clock
`timescale 1ns/100ps
module rcd_ext_load (
   input wire logic clk,
   input wire logic pinLevel,
   input wire logic measOn,
   output logic [15:0] highCount,
   output logic [15:0] riseCount
);

   logic lastLevel;
   logic wasOn;

   ////////////////////////////////////////////////////////////////////////
   // one look at the pin, counting high looks and low-to-high steps
   task automatic take();
      if (measOn) begin
         highCount += 16'(pinLevel);
         riseCount += 16'(pinLevel & ~lastLevel);
      end
      lastLevel = pinLevel;
   endtask : take

   initial begin
      highCount = 16'h0;
      riseCount = 16'h0;
      lastLevel = 1'b0;
      wasOn = 1'b0;
   end

   // looks at quarter and three-quarter points, clear of zero-width glitches
   always @(posedge clk) begin
      #1;
      if (measOn && !wasOn) begin
         highCount = 16'h0;
         riseCount = 16'h0;
      end
      wasOn = measOn;
      take();
      #2;
      take();
   end

endmodule : rcd_ext_load

// file: dv/tb_rcd_ref_clock.sv
// testbench for the reference clock output block
// assumes the register port of the block and the external load model
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      nTests++; \
      if ((got) !== (exp)) begin \
         badCount++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module tb_rcd_ref_clock;
   import rcd_pkg::*;

   logic clk;
   logic rstN;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData;
   logic wrStrobe, rdStrobe, sleep, lpMode, stdMode, hsMode, instrCfg, pinIn, measOn;
   logic [DATA_W-1:0] rdData;
   logic [DATA_W-1:0] rd;
   logic pinOut, pinOe, slewEn;
   logic [15:0] highCount, riseCount;
   int badCount, nTests;
   wire pinLevel = pinOe ? pinOut : pinIn;

   rcd_ref_clock uut (.clk(clk), .rst_n(rstN), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .sleep(sleep),
      .lowPowerCrystalMode(lpMode), .standardCrystalMode(stdMode),
      .highSpeedCrystalMode(hsMode), .instrClkOutCfg(instrCfg), .refClkPinIn(pinIn),
      .refClkPinOut(pinOut), .refClkPinOe(pinOe), .refSlewLimitEn(slewEn));

   rcd_ext_load load (.clk(clk), .pinLevel(pinLevel), .measOn(measOn),
      .highCount(highCount), .riseCount(riseCount));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // undriven pin: crystal swings it every cycle
   always @(posedge clk) pinIn <= pinOe ? pinOut : ~pinIn;

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask : wr

   task automatic rdReg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 rd = rdData;
   endtask : rdReg

   // 256 system cycles seen by the load
   task automatic measure();
      @(posedge clk) measOn <= 1'b1;
      repeat (256) @(posedge clk);
      measOn <= 1'b0;
   endtask : measure

   task automatic printVerdict();
      if (badCount == 0 && nTests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : printVerdict

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] cfg;
      int hiExp;
      rstN = 1'b0;
      {addr, wrData, wrStrobe, rdStrobe, sleep} = '0;
      {lpMode, stdMode, hsMode, instrCfg, pinIn, measOn} = '0;
      repeat (16) @(posedge clk);
      rstN <= 1'b1;
      rdReg(OFS_CTRL);
      `CHK(rd, CTRL_RESET)
      `CHK(slewEn, 1'b1)
      `CHK(({pinOe, pinOut}), 2'b10)
      wr(OFS_CTRL, 8'h80);
      rdReg(OFS_STATUS);
      `CHK(rd[ST_RUN], 1'b1)
      `CHK(rd[ST_PIN], 1'b0)
      measure();
      `CHK(riseCount, 16'h0)
      `CHK(highCount, 16'h0)
      wr(8'h02, 8'hff);
      rdReg(8'h02);
      `CHK(rd, 8'h00)
      rdReg(OFS_CTRL);
      `CHK(rd, 8'h80)
      for (int dv = 0; dv < 8; dv++) begin
         for (int du = 0; du < 4; du++) begin
            cfg = {1'b1, 1'b0, du[0], du[1:0], dv[2:0]};
            wr(OFS_CTRL, cfg);
            wr(OFS_CTRL, cfg | 8'h40);
            repeat (128) @(posedge clk);
            measure();
            hiExp = (du == 0) ? 0 : ((dv == 0) ? 256 : du * 128);
            `CHK(highCount, 16'(hiExp))
            `CHK(riseCount, 16'((du == 0) ? 0 : (256 >> dv)))
            `CHK(slewEn, du[0])
         end
      end
      wr(OFS_CTRL, 8'h92);
      wr(OFS_CTRL, 8'hd2);
      repeat (128) @(posedge clk);
      @(posedge clk) sleep <= 1'b1;
      wr(OFS_CTRL, 8'h00);
      measure();
      `CHK(riseCount, 16'h0)
      `CHK((highCount == 16'h0 || highCount == 16'd512), 1'b1)
      rdReg(OFS_STATUS);
      `CHK(rd[ST_SLEEP], 1'b1)
      `CHK(rd[ST_PIN], highCount[9])
      @(posedge clk) sleep <= 1'b0;
      rdReg(OFS_CTRL);
      `CHK(rd, 8'hd2)
      measure();
      `CHK(riseCount, 16'd64)
      for (int m = 0; m < 3; m++) begin
         @(posedge clk) {lpMode, stdMode, hsMode} <= 3'b100 >> m;
         rdReg(OFS_STATUS);
         `CHK(rd[ST_OSC], 1'b1)
         `CHK(pinOe, 1'b0)
      end
      @(posedge clk) {lpMode, stdMode, hsMode} <= 3'b000;
      instrCfg <= 1'b1;
      measure();
      `CHK(riseCount, 16'd64)
      `CHK(highCount, 16'd256)
      rdReg(OFS_STATUS);
      `CHK(rd[ST_INSTR], 1'b1)
      @(posedge clk) instrCfg <= 1'b0;
      rstN <= 1'b0;
      repeat (2) @(posedge clk);
      rstN <= 1'b1;
      rdReg(OFS_CTRL);
      `CHK(rd, CTRL_RESET)
      measure();
      `CHK(riseCount, 16'h0)
      `CHK(({pinOe, pinOut}), 2'b10)
      printVerdict();
   end

   // hang guard, well beyond the sweep length
   initial begin
      repeat (40000) @(posedge clk);
      badCount++;
      printVerdict();
   end

endmodule : tb_rcd_ref_clock

// file: hw/rcd_divider.sv
// power-of-two counter and duty shaper for the reference output
// assumes run and freeze come from logic on the same clock
`timescale 1ns/100ps
module rcd_divider (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic freeze,
   input wire logic [rcd_pkg::DIV_W-1:0] divSel,
   input wire logic [rcd_pkg::DUTY_W-1:0] dutySel,
   output logic [rcd_pkg::CNT_W-1:0] count,
   output logic wave
);
   import rcd_pkg::*;

   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] lastCount;
   logic [7:0] highCount;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      lastCount = rcd_div_last(divSel);
      highCount = rcd_high_count(divSel, dutySel);
      if (!run) begin
         next_count = '0;
      end else if (count == lastCount) begin
         next_count = '0;
      end else begin
         next_count = count + 7'h01;
      end
   end

   // frozen while the system clock is stopped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (!freeze) begin
         count <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wave <= 1'b0;
      end else if (!freeze) begin
         wave <= run && ({1'b0, next_count} < highCount);
      end
   end

endmodule : rcd_divider

// file: hw/rcd_ref_clock.sv
// reference clock output: control register, divider and pin ownership
// assumes config straps and sleep are on the system clock; pin input is not
`timescale 1ns/100ps
module rcd_ref_clock (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [rcd_pkg::ADDR_W-1:0] addr,
   input wire logic [rcd_pkg::DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [rcd_pkg::DATA_W-1:0] rdData,
   input wire logic sleep,
   input wire logic lowPowerCrystalMode,
   input wire logic standardCrystalMode,
   input wire logic highSpeedCrystalMode,
   input wire logic instrClkOutCfg,
   input wire logic refClkPinIn,
   output logic refClkPinOut,
   output logic refClkPinOe,
   output logic refSlewLimitEn
);
   import rcd_pkg::*;

   logic [DATA_W-1:0] refClockCtrl;
   logic refModuleEn;
   logic refPinOutEn;
   logic [DIV_W-1:0] refDivSel;
   logic [DUTY_W-1:0] refDutySel;
   logic [CNT_W-1:0] divCount;
   logic divWave;
   logic [INSTR_CNT_W-1:0] instrCnt;
   logic instrWave;
   logic pinMeta;
   logic pinSync;
   logic crystalMode;
   logic clkTerm;
   logic refSignal;
   logic [DATA_W-1:0] statusWord;
   rcd_pin_src_e pinSrc;

   ////////////////////////////////////////////////////////////////////////
   // control register
   assign refModuleEn = refClockCtrl[BIT_MOD_EN];
   assign refPinOutEn = refClockCtrl[BIT_PIN_OE];
   assign refDivSel = refClockCtrl[DIV_LSB +: DIV_W];
   assign refDutySel = refClockCtrl[DUTY_LSB +: DUTY_W];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refClockCtrl <= CTRL_RESET;
      end else if (wrStrobe && !sleep && addr == OFS_CTRL) begin
         refClockCtrl <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refSlewLimitEn <= CTRL_RESET[BIT_SLEW];
      end else if (wrStrobe && !sleep && addr == OFS_CTRL) begin
         refSlewLimitEn <= wrData[BIT_SLEW];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read side: data stands only in the cycle after the strobe
   always_comb begin
      statusWord = '0;
      statusWord[ST_RUN] = refModuleEn;
      statusWord[ST_OSC] = crystalMode;
      statusWord[ST_INSTR] = instrClkOutCfg && !crystalMode;
      statusWord[ST_PIN] = pinSync;
      statusWord[ST_SLEEP] = sleep;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData <= '0;
      end else if (rdStrobe) begin
         if (addr == OFS_CTRL) begin
            rdData <= refClockCtrl;
         end else if (addr == OFS_STATUS) begin
            rdData <= statusWord;
         end else begin
            rdData <= '0;
         end
      end else begin
         rdData <= '0;
      end
   end

   // pin level seen back, two stages
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
      end else begin
         pinMeta <= refClkPinIn;
         pinSync <= pinMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // divider
   // run gate
   rcd_divider u_div (
      .clk(clk),
      .rst_n(rst_n),
      .run(refModuleEn),
      .freeze(sleep),
      .divSel(refDivSel),
      .dutySel(refDutySel),
      .count(divCount),
      .wave(divWave)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         instrCnt <= '0;
      end else if (!sleep) begin
         instrCnt <= instrCnt + 2'h1;
      end
   end
   assign instrWave = instrCnt[INSTR_CNT_W-1];

   ////////////////////////////////////////////////////////////////////////
   // waveform shaping
   // system clock source
   assign clkTerm = clk && !sleep;

   always_comb begin
      if (refDivSel == DIV_NONE) begin
         refSignal = (refDutySel == DUTY_ZERO) ? 1'b0 : clkTerm;
      end else if (refDivSel == DIV_TWO && refDutySel == DUTY_QUARTER) begin
         refSignal = divWave && clkTerm;
      end else if (refDivSel == DIV_TWO && refDutySel == DUTY_THREE_Q) begin
         refSignal = divWave || clkTerm;
      end else begin
         refSignal = divWave;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin ownership
   assign crystalMode = lowPowerCrystalMode || standardCrystalMode || highSpeedCrystalMode;

   always_comb begin
      if (crystalMode) begin
         pinSrc = SRC_OSC_IN;
      end else if (instrClkOutCfg) begin
         pinSrc = SRC_INSTR;
      end else if (refModuleEn && refPinOutEn) begin
         pinSrc = SRC_REF;
      end else begin
         pinSrc = SRC_IDLE;
      end
   end

   always_comb begin
      case (pinSrc)
         SRC_OSC_IN: begin
            refClkPinOe = 1'b0;
            refClkPinOut = 1'b0;
         end
         SRC_INSTR: begin
            refClkPinOe = 1'b1;
            refClkPinOut = instrWave;
         end
         SRC_REF: begin
            refClkPinOe = 1'b1;
            refClkPinOut = refSignal;
         end
         default: begin
            refClkPinOe = 1'b1;
            refClkPinOut = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [CNT_W-1:0] chkLast;
   logic [7:0] chkHigh;
   assign chkLast = rcd_div_last(refDivSel);
   assign chkHigh = rcd_high_count(refDivSel, refDutySel);

   sequence ctrlWrite_s;
      wrStrobe && !sleep && addr == OFS_CTRL;
   endsequence

   sequence steadyRun_s;
      refModuleEn && !sleep ##1 refModuleEn && !sleep && $stable(refClockCtrl);
   endsequence

   resetCtrl_a: assert property (
      @(posedge clk) $rose(rst_n) |-> refClockCtrl == CTRL_RESET && divCount == '0
         && refSlewLimitEn == CTRL_RESET[BIT_SLEW])
      else $error("control not at defaults after reset");

   disabledHold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !refModuleEn && !sleep |=> divCount == '0 && !divWave)
      else $error("divider moved while disabled");

   wrapCount_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      refModuleEn && !sleep && divCount == chkLast |=> divCount == '0)
      else $error("divider did not wrap at its period");

   stepCount_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      refModuleEn && !sleep && divCount < chkLast |=> divCount == $past(divCount) + 7'h01)
      else $error("divider count did not advance");

   dutyShape_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      steadyRun_s |-> divWave == ({1'b0, divCount} < chkHigh))
      else $error("duty high time wrong");

   zeroDuty_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      pinSrc == SRC_REF && refDutySel == DUTY_ZERO && !sleep ##1 $stable(refClockCtrl)
         |-> !refClkPinOut)
      else $error("zero duty output not low");

   slewFollow_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      ctrlWrite_s |=> refSlewLimitEn == $past(wrData[BIT_SLEW]))
      else $error("slew control did not follow write");

   oscPin_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      crystalMode |-> !refClkPinOe)
      else $error("pin driven in crystal mode");

   idleLow_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !crystalMode && !instrClkOutCfg && !sleep && !(refModuleEn && refPinOutEn)
         |-> refClkPinOe && !refClkPinOut)
      else $error("idle pin not driven low");

   instrRate_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n, 3) && !sleep ##1 !sleep ##1 !sleep && instrClkOutCfg && !crystalMode
         |-> refClkPinOut == !$past(instrWave, 2))
      else $error("instruction clock not a quarter rate");

   sleepHold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      sleep ##1 sleep |-> $stable(refClkPinOut) && $stable(divCount) && $stable(instrCnt))
      else $error("outputs moved during sleep");

endmodule : rcd_ref_clock

// file: shared/rcd_pkg.sv
// constants and helpers for the reference clock divider block
// assumes a single system clock; all users import the whole package
package rcd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register port, field and counter widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int DIV_W = 3;
   localparam int DUTY_W = 2;
   localparam int CNT_W = 7;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h01;

   // control register fields
   localparam int BIT_MOD_EN = 7;
   localparam int BIT_PIN_OE = 6;
   localparam int BIT_SLEW = 5;
   localparam int DUTY_LSB = 3;
   localparam int DIV_LSB = 0;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h30;

   // status register fields
   localparam int ST_RUN = 0;
   localparam int ST_OSC = 1;
   localparam int ST_INSTR = 2;
   localparam int ST_PIN = 3;
   localparam int ST_SLEEP = 4;

   ////////////////////////////////////////////////////////////////////////
   // field encodings
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 2'h0;
   localparam logic [DUTY_W-1:0] DUTY_QUARTER = 2'h1;
   localparam logic [DUTY_W-1:0] DUTY_HALF = 2'h2;
   localparam logic [DUTY_W-1:0] DUTY_THREE_Q = 2'h3;
   localparam logic [DIV_W-1:0] DIV_NONE = 3'h0;
   localparam logic [DIV_W-1:0] DIV_TWO = 3'h1;

   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int INSTR_DIV = 4;
   localparam int INSTR_CNT_W = $clog2(INSTR_DIV);

   // what owns the shared pin
   typedef enum {SRC_OSC_IN, SRC_INSTR, SRC_REF, SRC_IDLE} rcd_pin_src_e;

   ////////////////////////////////////////////////////////////////////////
   // last count of one output period
   function automatic logic [CNT_W-1:0] rcd_div_last(input logic [DIV_W-1:0] sel);
      logic [7:0] period;
      period = 8'h01 << sel;
      return CNT_W'(period - 8'h01);
   endfunction : rcd_div_last

   // counts of the period during which the output is high
   function automatic logic [7:0] rcd_high_count(input logic [DIV_W-1:0] sel,
                                                 input logic [DUTY_W-1:0] duty);
      logic [7:0] period;
      logic [7:0] result;
      period = 8'h01 << sel;
      case (duty)
         DUTY_ZERO: result = 8'h00;
         DUTY_QUARTER: result = (sel == DIV_TWO) ? (period >> 1) : (period >> 2);
         DUTY_HALF: result = period >> 1;
         default: result = (sel == DIV_TWO) ? (period >> 1) : ((period >> 1) + (period >> 2));
      endcase
      return result;
   endfunction : rcd_high_count

endpackage : rcd_pkg
